// >>> tb/can_bus_model.sv
// Protocol engine and bus model driving the block's event inputs.
// Assumes its tasks are called by the bench just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module can_bus_model
   import can_stat_pkg::*;
(
   input wire logic clk_sys,                 // System clock.
   output var can_stat_pkg::engine_ev_t ev   // Engine events.
);
   initial ev = '0;
   task automatic levels(input logic [8:0] rx, input logic [8:0] tx,
         input logic slp);
      @(posedge clk_sys);
      ev.rx_error_count <= rx;
      ev.tx_error_count <= tx;
      ev.sleeping <= slp;
   endtask
   // Raises the given event bits for exactly one clock.
   task automatic pulse(input engine_ev_t p);
      @(posedge clk_sys);
      ev <= ev | p;
      @(posedge clk_sys);
      ev <= ev & ~p;
   endtask
   // Each run is 11 recessive bits closed by one dominant bit.
   task automatic idle_runs(input int runs);
      for (int r = 0; r < runs; r++) begin
         repeat (11) pulse('{recessive_bit: 1'b1, default: 0});
         pulse('{dominant_bit: 1'b1, default: 0});
      end
   endtask
endmodule
`default_nettype wire

// >>> tb/can_status_irq_abort_filter_ctrl_test.sv
// Self-checking bench for the CAN status, interrupt and abort block.
// Assumes can_bus_model stands in for the protocol engine.
`timescale 1ns/1ps
`default_nettype none
module can_status_irq_abort_filter_ctrl_test;
   import can_stat_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   reg_req_t req = '0;
   engine_ev_t ev;
   logic [7:0] rdata;
   logic fg_load, soft_reset_bit, wakeup_irq, error_irq, rx_irq, tx_irq;
   logic [2:0] abort_grant;
   logic [1:0] filter_mode;
   int err_count = 0;
   int checks_done = 0;
   int loads = 0;
   int grants = 0;
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (fg_load === 1'b1) loads++;
      if (abort_grant !== 3'b000) grants++;
   end
   can_stat_ctrl DUT (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
      .rdata(rdata), .ev(ev), .fg_load(fg_load), .abort_grant(abort_grant),
      .filter_mode(filter_mode), .soft_reset_bit(soft_reset_bit),
      .wakeup_irq(wakeup_irq), .error_irq(error_irq), .rx_irq(rx_irq),
      .tx_irq(tx_irq));
   can_bus_model bus (.clk_sys(clk_sys), .ev(ev));
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [7:0] e,
         input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      req <= '0;
      #1;
   endtask
   // Reads one register and compares the masked value.
   task automatic rchk(input string s, input logic [3:0] a,
         input logic [7:0] m, input logic [7:0] e);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      req <= '0;
      #1;
      chk(s, e, rdata & m);
   endtask
   task automatic t_soft_reset();
      chk("soft_reset_bit", 8'h01, soft_reset_bit);
      rchk("module ctrl", OFS_MODULE_CTRL, 8'hff, RST_MODULE_CTRL);
      rchk("tx flags", OFS_TX_FLAGS, 8'hff, 8'h07);
      bus.pulse('{overrun: 1'b1, default: 0});
      rchk("rx flags held", OFS_RX_FLAGS, 8'hff, 8'h00);
      bus.levels(9'd5, 9'd9, 1'b0);
      rchk("rx err view", OFS_RX_ERR, 8'hff, 8'h05);
      rchk("tx err view", OFS_TX_ERR, 8'hff, 8'h09);
      rchk("unmapped", 4'hf, 8'hff, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(OFS_FILTER, 8'(m << 4));
         chk("filter_mode", 8'(m), filter_mode);
      end
   endtask
   task automatic t_closed();
      int n;
      n = loads;
      wr(OFS_MODULE_CTRL, 8'h00);
      chk("soft_reset_bit", 8'h00, soft_reset_bit);
      wr(OFS_FILTER, 8'h00);
      chk("filter locked", 8'h03, filter_mode);
      bus.pulse('{rx_msg_ok: 1'b1, default: 0});
      rchk("closed rx full", OFS_RX_FLAGS, 8'h01, 8'h00);
      chk("closed loads", 8'(n), 8'(loads));
      rchk("err view hidden", OFS_RX_ERR, 8'hff, 8'h00);
      bus.levels(9'd5, 9'd9, 1'b1);
      rchk("sleep err view", OFS_TX_ERR, 8'hff, 8'h09);
      bus.levels(9'd0, 9'd0, 1'b0);
      wr(OFS_MODULE_CTRL, 8'h01);
      wr(OFS_FILTER, 8'h00);
      wr(OFS_MODULE_CTRL, 8'h00);
   endtask
   task automatic t_rx_full();
      int n;
      n = loads;
      wr(OFS_RX_IEN, 8'h01);
      bus.pulse('{rx_msg_ok: 1'b1, rx_hit: 2'd2, default: 0});
      rchk("rx full", OFS_RX_FLAGS, 8'h01, 8'h01);
      rchk("hit two", OFS_FILTER, 8'h03, 8'h02);
      chk("rx_irq", 8'h01, rx_irq);
      wr(OFS_RX_FLAGS, 8'h01);
      rchk("rx full clear", OFS_RX_FLAGS, 8'h01, 8'h00);
      bus.pulse('{rx_msg_ok: 1'b1, rx_hit: 2'd1, default: 0});
      bus.pulse('{rx_msg_ok: 1'b1, rx_hit: 2'd3, default: 0});
      rchk("hit kept", OFS_FILTER, 8'h03, 8'h01);
      chk("loads", 8'(n + 2), 8'(loads));
   endtask
   task automatic t_err_flags();
      wr(OFS_RX_IEN, 8'h82);
      bus.pulse('{overrun: 1'b1, default: 0});
      bus.levels(9'd0, 9'd0, 1'b1);
      bus.pulse('{wakeup: 1'b1, default: 0});
      bus.levels(9'd0, 9'd0, 1'b0);
      rchk("ovr wakeup", OFS_RX_FLAGS, 8'h82, 8'h82);
      chk("error_irq", 8'h01, error_irq);
      chk("wakeup_irq", 8'h01, wakeup_irq);
      wr(OFS_RX_IEN, 8'h00);
      rchk("ovr sticky", OFS_RX_FLAGS, 8'h82, 8'h82);
      chk("error masked", 8'h00, error_irq);
      wr(OFS_RX_FLAGS, 8'h82);
      rchk("ovr cleared", OFS_RX_FLAGS, 8'h82, 8'h00);
      wr(OFS_RX_IEN, 8'h40);
      bus.levels(9'd96, 9'd0, 1'b0);
      rchk("warn at 96", OFS_RX_FLAGS, 8'h40, 8'h00);
      bus.levels(9'd97, 9'd0, 1'b0);
      rchk("warn at 97", OFS_RX_FLAGS, 8'h40, 8'h40);
      chk("warn irq", 8'h01, error_irq);
      wr(OFS_RX_FLAGS, 8'h40);
      rchk("warn kept", OFS_RX_FLAGS, 8'h40, 8'h40);
   endtask
   task automatic t_busoff();
      wr(OFS_RX_IEN, 8'h04);
      bus.levels(9'd0, 9'd255, 1'b0);
      rchk("busoff 255", OFS_RX_FLAGS, 8'h04, 8'h00);
      bus.levels(9'd0, 9'd256, 1'b0);
      rchk("busoff 256", OFS_RX_FLAGS, 8'h04, 8'h04);
      chk("busoff irq", 8'h01, error_irq);
      bus.levels(9'd0, 9'd0, 1'b0);
      bus.idle_runs(127);
      wr(OFS_RX_FLAGS, 8'h04);
      rchk("busoff held", OFS_RX_FLAGS, 8'h04, 8'h04);
      bus.idle_runs(1);
      wr(OFS_RX_FLAGS, 8'h04);
      rchk("busoff clear", OFS_RX_FLAGS, 8'h04, 8'h00);
   endtask
   task automatic t_tx(input int i);
      logic [7:0] e;
      int n;
      e = 8'(1 << i);
      n = grants;
      wr(OFS_TX_CTRL, e);
      wr(OFS_TX_FLAGS, e);
      rchk("empty clear", OFS_TX_FLAGS, 8'h77, 8'h07 & ~e);
      chk("tx_irq masked", 8'h00, tx_irq);
      wr(OFS_TX_FLAGS, 8'h70);
      rchk("zero write", OFS_TX_FLAGS, 8'h77, 8'h07 & ~e);
      wr(OFS_TX_CTRL, e | (e << 4));
      wr(OFS_TX_CTRL, e);
      rchk("abort kept", OFS_TX_CTRL, 8'h77, e | (e << 4));
      bus.pulse('{tx_abortable: e[2:0], default: 0});
      rchk("abort ack", OFS_TX_FLAGS, 8'h77, 8'h07 | (e << 4));
      rchk("abort gone", OFS_TX_CTRL, 8'h77, e);
      chk("grants", 8'(n + 1), 8'(grants));
      chk("tx_irq", 8'h01, tx_irq);
      wr(OFS_TX_FLAGS, e);
      rchk("ack cleared", OFS_TX_FLAGS, 8'h77, 8'h07 & ~e);
      bus.pulse('{tx_done: e[2:0], default: 0});
      rchk("sent", OFS_TX_FLAGS, 8'h77, 8'h07);
   endtask
   task automatic t_hold();
      wr(OFS_RX_IEN, 8'hff);
      wr(OFS_TX_CTRL, 8'h07);
      wr(OFS_TX_FLAGS, 8'h07);
      wr(OFS_MODULE_CTRL, 8'h01);
      rchk("ien reset", OFS_RX_IEN, 8'hff, 8'h00);
      rchk("ctrl reset", OFS_TX_CTRL, 8'hff, 8'h00);
      rchk("tx reset", OFS_TX_FLAGS, 8'hff, 8'h07);
      rchk("rx reset", OFS_RX_FLAGS, 8'hff, 8'h00);
   endtask
   initial begin
      repeat (100000) @(posedge clk_sys);
      err_count++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      t_soft_reset();
      t_closed();
      t_rx_full();
      t_err_flags();
      t_busoff();
      for (int i = 0; i < NUM_TX; i++) t_tx(i);
      t_hold();
      complete_run();
   end
endmodule
`default_nettype wire

// >>> verilog/can_stat_ctrl.sv
// CAN controller status, interrupt-request and transmit-abort logic.
// Assumes protocol-engine events arrive synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module can_stat_ctrl
   import can_stat_pkg::*;
(
   input wire logic clk_sys,                    // System clock.
   input wire logic rst_n,                      // Asynchronous reset.
   input wire can_stat_pkg::reg_req_t req,      // Register request.
   output logic [7:0] rdata,                    // Read data, next cycle.
   input wire can_stat_pkg::engine_ev_t ev,     // Protocol engine events.
   output logic fg_load,                        // Foreground buffer load.
   output logic [2:0] abort_grant,              // Buffer abort taken.
   output logic [1:0] filter_mode,              // Filter organisation.
   output logic soft_reset_bit,                 // Soft reset state.
   output logic wakeup_irq,                     // Wakeup interrupt.
   output logic error_irq,                      // Error interrupt.
   output logic rx_irq,                         // Receive interrupt.
   output logic tx_irq                          // Transmit-empty interrupt.
);
   import can_stat_pkg::*;

   logic [7:0] module_ctrl_q;
   logic [7:0] rx_flags_q;
   logic [7:0] rx_ien_q;
   logic [2:0] tx_buf_empty_q;
   logic [2:0] abort_ack_q;
   logic [2:0] abort_request_q;
   logic [2:0] tx_empty_irq_en_q;
   logic [1:0] filter_mode_q;
   logic [1:0] filter_hit_q;
   logic [7:0] rdata_q;
   logic fg_load_q;
   logic [2:0] abort_grant_q;
   logic wakeup_irq_q, error_irq_q, rx_irq_q, tx_irq_q;
   busoff_state_t bo_state_q;
   logic [3:0] rec_run_q;
   logic [7:0] rec_seq_q;

   logic srst;
   logic wr_rxf, wr_rxie, wr_txf, wr_txc, wr_fil, wr_mc;
   logic [7:0] rx_set, rx_cond, rx_clr;
   logic [2:0] tx_set, tx_clr;
   logic load_ok;
   logic busoff_cond;

   assign srst = module_ctrl_q[B_SOFT_RESET];
   assign wr_rxf = req.wr && req.addr == OFS_RX_FLAGS;
   assign wr_rxie = req.wr && req.addr == OFS_RX_IEN;
   assign wr_txf = req.wr && req.addr == OFS_TX_FLAGS;
   assign wr_txc = req.wr && req.addr == OFS_TX_CTRL;
   assign wr_fil = req.wr && req.addr == OFS_FILTER;
   assign wr_mc = req.wr && req.addr == OFS_MODULE_CTRL;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         module_ctrl_q <= RST_MODULE_CTRL;
      end else if (wr_mc) begin
         module_ctrl_q <= req.wdata;
      end
   end

   // Bus-off recovery counts runs of 11 recessive bits, 128 of them.
   assign busoff_cond = ev.tx_error_count > BUSOFF_LIMIT;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bo_state_q <= BO_IDLE;
         rec_run_q <= 4'h0;
         rec_seq_q <= 8'h00;
      end else begin
         case (bo_state_q)
            BO_IDLE: begin
               if (busoff_cond) begin
                  bo_state_q <= BO_ACTIVE;
                  rec_run_q <= 4'h0;
                  rec_seq_q <= 8'h00;
               end
            end
            BO_ACTIVE: begin
               if (ev.dominant_bit) begin
                  rec_run_q <= 4'h0;
               end else if (ev.recessive_bit) begin
                  if (rec_run_q == RECOV_BITS - 4'h1) begin
                     rec_run_q <= 4'h0;
                     if (rec_seq_q == RECOV_SEQS - 8'h01) begin
                        bo_state_q <= BO_RECOVERED;
                     end
                     rec_seq_q <= rec_seq_q + 8'h01;
                  end else begin
                     rec_run_q <= rec_run_q + 4'h1;
                  end
               end
            end
            BO_RECOVERED: begin
               if (!rx_flags_q[B_BUSOFF]) begin
                  bo_state_q <= BO_IDLE;
               end
            end
            default: bo_state_q <= BO_IDLE;
         endcase
      end
   end

   // Foreground load: closed filter or full buffer blocks it.
   assign load_ok = ev.rx_msg_ok && !rx_flags_q[B_RX_FULL]
                    && filter_mode_q != MODE_CLOSED
                    && !srst;

   always_comb begin
      rx_set = 8'h00;
      rx_set[B_WAKEUP] = ev.wakeup && ev.sleeping;
      rx_set[B_RX_WARN] = ev.rx_error_count > WARN_LIMIT
         && !rx_flags_q[B_RX_PASS] && !rx_flags_q[B_TX_PASS]
         && !rx_flags_q[B_BUSOFF];
      rx_set[B_TX_WARN] = ev.tx_error_count > WARN_LIMIT
         && !rx_flags_q[B_RX_PASS] && !rx_flags_q[B_TX_PASS]
         && !rx_flags_q[B_BUSOFF];
      rx_set[B_RX_PASS] = ev.rx_error_count > PASS_LIMIT
         && !rx_flags_q[B_BUSOFF];
      rx_set[B_TX_PASS] = ev.tx_error_count > PASS_LIMIT
         && !rx_flags_q[B_BUSOFF];
      rx_set[B_BUSOFF] = busoff_cond;
      rx_set[B_OVERRUN] = ev.overrun;
      rx_set[B_RX_FULL] = load_ok;
      // Causes still present block a clear.
      rx_cond = rx_set;
      rx_cond[B_BUSOFF] = bo_state_q != BO_RECOVERED;
      rx_clr = wr_rxf ? (req.wdata & ~rx_cond) : 8'h00;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_flags_q <= 8'h00;
      end else if (srst) begin
         rx_flags_q <= 8'h00;
      end else begin
         rx_flags_q <= (rx_flags_q & ~rx_clr) | rx_set;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_ien_q <= 8'h00;
      end else if (srst) begin
         rx_ien_q <= 8'h00;
      end else if (wr_rxie) begin
         rx_ien_q <= req.wdata;
      end
   end

   // Abort is granted only when the engine says the buffer is abortable.
   always_comb begin
      for (int i = 0; i < NUM_TX; i++) begin
         tx_set[i] = ev.tx_done[i] || (abort_request_q[i]
                     && ev.tx_abortable[i] && !tx_buf_empty_q[i]);
      end
      tx_clr = wr_txf ? req.wdata[NUM_TX-1:0] : 3'h0;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_buf_empty_q <= 3'h7;
         abort_ack_q <= 3'h0;
      end else if (srst) begin
         tx_buf_empty_q <= 3'h7;
         abort_ack_q <= 3'h0;
      end else begin
         for (int i = 0; i < NUM_TX; i++) begin
            if (tx_set[i]) begin
               tx_buf_empty_q[i] <= 1'b1;
               abort_ack_q[i] <= !ev.tx_done[i];
            end else if (tx_clr[i]) begin
               tx_buf_empty_q[i] <= 1'b0;
               abort_ack_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         abort_request_q <= 3'h0;
         tx_empty_irq_en_q <= 3'h0;
      end else if (srst) begin
         abort_request_q <= 3'h0;
         tx_empty_irq_en_q <= 3'h0;
      end else begin
         for (int i = 0; i < NUM_TX; i++) begin
            if (tx_set[i]) begin
               abort_request_q[i] <= 1'b0;
            end else if (wr_txc && req.wdata[B_ABORT_LO + i]) begin
               abort_request_q[i] <= 1'b1;
            end
         end
         if (wr_txc) begin
            tx_empty_irq_en_q <= req.wdata[NUM_TX-1:0];
         end
      end
   end

   // Filter mode and hit.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         filter_mode_q <= 2'b00;
         filter_hit_q <= 2'b00;
      end else begin
         if (wr_fil && srst) begin
            filter_mode_q <= req.wdata[5:4];
         end
         if (load_ok) begin
            filter_hit_q <= ev.rx_hit;
         end
      end
   end

   // Interrupt lines.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wakeup_irq_q <= 1'b0;
         error_irq_q <= 1'b0;
         rx_irq_q <= 1'b0;
         tx_irq_q <= 1'b0;
      end else begin
         wakeup_irq_q <= rx_flags_q[B_WAKEUP]
            && rx_ien_q[B_WAKEUP];
         error_irq_q <= |(rx_flags_q[B_RX_WARN:B_OVERRUN]
            & rx_ien_q[B_RX_WARN:B_OVERRUN]);
         rx_irq_q <= rx_flags_q[B_RX_FULL]
            && rx_ien_q[B_RX_FULL];
         tx_irq_q <= |(tx_buf_empty_q & tx_empty_irq_en_q);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fg_load_q <= 1'b0;
         abort_grant_q <= 3'h0;
      end else begin
         fg_load_q <= load_ok;
         // A soft reset wipes the buffer flags, so no grant is reported then.
         abort_grant_q <= srst ? 3'h0 : (tx_set & ~ev.tx_done);
      end
   end

   // Read port; counters read as zero outside sleep or soft reset.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (req.rd) begin
         case (req.addr)
            OFS_RX_FLAGS: rdata_q <= rx_flags_q;
            OFS_RX_IEN: rdata_q <= rx_ien_q;
            OFS_TX_FLAGS: rdata_q <= {1'b0, abort_ack_q, 1'b0, tx_buf_empty_q};
            OFS_TX_CTRL: rdata_q <= {1'b0, abort_request_q, 1'b0,
                                     tx_empty_irq_en_q};
            OFS_FILTER: rdata_q <= {2'b00, filter_mode_q, 2'b00, filter_hit_q};
            OFS_RX_ERR: rdata_q <= (srst || ev.sleeping)
                                   ? ev.rx_error_count[7:0] : 8'h00;
            OFS_TX_ERR: rdata_q <= (srst || ev.sleeping)
                                   ? ev.tx_error_count[7:0] : 8'h00;
            OFS_MODULE_CTRL: rdata_q <= {module_ctrl_q[7:2], ev.sleeping,
                                         module_ctrl_q[B_SOFT_RESET]};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata = rdata_q;
   assign fg_load = fg_load_q;
   assign abort_grant = abort_grant_q;
   assign filter_mode = filter_mode_q;
   assign soft_reset_bit = module_ctrl_q[B_SOFT_RESET];
   assign wakeup_irq = wakeup_irq_q;
   assign error_irq = error_irq_q;
   assign rx_irq = rx_irq_q;
   assign tx_irq = tx_irq_q;

   // All checks run on the system clock and sleep through a hard reset.
   default clocking chk_clk @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   chk_rxfull_blocks_load: assert property (
      rx_flags_q[B_RX_FULL] |=> !fg_load_q)
      else $error("load while receive full");
   chk_closed_no_load: assert property (
      filter_mode_q == MODE_CLOSED |=> !fg_load_q)
      else $error("load in closed mode");
   chk_empty_clears_abort: assert property (
      $rose(tx_buf_empty_q[0]) |-> !abort_request_q[0])
      else $error("abort request survives empty");
   chk_empty_clears_abort1: assert property (
      $rose(tx_buf_empty_q[1]) |-> !abort_request_q[1])
      else $error("abort request one survives empty");
   chk_empty_clears_abort2: assert property (
      $rose(tx_buf_empty_q[2]) |-> !abort_request_q[2])
      else $error("abort request two survives empty");
   chk_busoff_sets: assert property (
      busoff_cond && !srst |=> rx_flags_q[B_BUSOFF])
      else $error("bus-off not set");
   chk_soft_reset_hold: assert property (
      srst |=> rx_flags_q == 8'h00 && rx_ien_q == 8'h00)
      else $error("soft reset not holding");
   chk_soft_reset_tx: assert property (
      srst |=> tx_buf_empty_q == 3'h7 && abort_ack_q == 3'h0
         && abort_request_q == 3'h0 && tx_empty_irq_en_q == 3'h0)
      else $error("soft reset not holding transmit side");
   chk_filter_locked: assert property (
      !srst && !$past(srst) |=> $stable(filter_mode_q))
      else $error("filter mode changed outside soft reset");
   chk_ack_with_empty: assert property (
      abort_ack_q[1] |-> tx_buf_empty_q[1])
      else $error("ack without empty");
   chk_ack_with_empty0: assert property (
      abort_ack_q[0] |-> tx_buf_empty_q[0])
      else $error("ack zero without empty");
   chk_ack_with_empty2: assert property (
      abort_ack_q[2] |-> tx_buf_empty_q[2])
      else $error("ack two without empty");
   chk_txirq_follows: assert property (
      (tx_buf_empty_q & tx_empty_irq_en_q) == 3'h0 |=> !tx_irq_q)
      else $error("tx irq without enabled empty");
   chk_txirq_sets: assert property (
      (tx_buf_empty_q & tx_empty_irq_en_q) != 3'h0 |=> tx_irq_q)
      else $error("tx irq missing for enabled empty");
   chk_busoff_sticky: assert property (
      rx_flags_q[B_BUSOFF] && bo_state_q == BO_ACTIVE && !srst
      |=> rx_flags_q[B_BUSOFF])
      else $error("bus-off cleared early");
   chk_busoff_waits: assert property (
      $fell(rx_flags_q[B_BUSOFF])
      |-> $past(srst) || $past(bo_state_q) == BO_RECOVERED)
      else $error("bus-off cleared before recovery");
   chk_overrun_sets: assert property (
      ev.overrun && !srst |=> rx_flags_q[B_OVERRUN])
      else $error("overrun not set");
   chk_rx_full_sets: assert property (
      fg_load_q |-> rx_flags_q[B_RX_FULL])
      else $error("load without receive full");
   chk_hit_follows_load: assert property (
      fg_load_q |-> filter_hit_q == $past(ev.rx_hit))
      else $error("hit not taken with load");
   chk_warn_gated: assert property (
      $rose(rx_flags_q[B_RX_WARN]) |-> !$past(rx_flags_q[B_BUSOFF]))
      else $error("warning set during bus-off");
   chk_grant_sets_ack: assert property (
      abort_grant_q != 3'h0
      |-> (abort_grant_q & ~(tx_buf_empty_q & abort_ack_q)) == 3'h0)
      else $error("grant without empty and ack");
   chk_wakeup_irq: assert property (
      rx_flags_q[B_WAKEUP] && rx_ien_q[B_WAKEUP] |=> wakeup_irq_q)
      else $error("wakeup irq missing");
   chk_error_irq: assert property (
      |(rx_flags_q[B_RX_WARN:B_OVERRUN] & rx_ien_q[B_RX_WARN:B_OVERRUN])
      |=> error_irq_q)
      else $error("error irq missing");
   chk_rx_irq: assert property (
      rx_flags_q[B_RX_FULL] && rx_ien_q[B_RX_FULL] |=> rx_irq_q)
      else $error("receive irq missing");
endmodule
`default_nettype wire

// >>> verilog/can_stat_pkg.sv
// Package for the CAN status, interrupt and abort block.
// Assumes one 100 MHz clock domain and an 8-bit register port.
package can_stat_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_RX_FLAGS = 4'h0;
   localparam logic [3:0] OFS_RX_IEN = 4'h1;
   localparam logic [3:0] OFS_TX_FLAGS = 4'h2;
   localparam logic [3:0] OFS_TX_CTRL = 4'h3;
   localparam logic [3:0] OFS_FILTER = 4'h4;
   localparam logic [3:0] OFS_RX_ERR = 4'h5;
   localparam logic [3:0] OFS_TX_ERR = 4'h6;
   localparam logic [3:0] OFS_MODULE_CTRL = 4'h7;
   // Receive flag and enable bit positions.
   localparam int B_WAKEUP = 7;
   localparam int B_RX_WARN = 6;
   localparam int B_TX_WARN = 5;
   localparam int B_RX_PASS = 4;
   localparam int B_TX_PASS = 3;
   localparam int B_BUSOFF = 2;
   localparam int B_OVERRUN = 1;
   localparam int B_RX_FULL = 0;
   // Transmit flag layout: ack in 6:4, empty in 2:0; ctrl likewise.
   localparam int B_ABORT_LO = 4;
   localparam int B_SOFT_RESET = 0;
   localparam int B_SLEEP = 1;
   localparam int NUM_TX = 3;
   localparam logic [8:0] WARN_LIMIT = 9'd96;
   localparam logic [8:0] PASS_LIMIT = 9'd127;
   localparam logic [8:0] BUSOFF_LIMIT = 9'd255;
   localparam logic [7:0] RECOV_SEQS = 8'd128;
   localparam logic [3:0] RECOV_BITS = 4'd11;
   localparam logic [7:0] RST_MODULE_CTRL = 8'h01;
   localparam logic [1:0] MODE_CLOSED = 2'b11;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // Events from the protocol engine, one clock each unless noted.
   typedef struct packed {
      logic [8:0] rx_error_count;   // Level.
      logic [8:0] tx_error_count;   // Level.
      logic sleeping;               // Level.
      logic wakeup;
      logic overrun;
      logic rx_msg_ok;              // Background buffer holds a message.
      logic [1:0] rx_hit;           // Filter that accepted it.
      logic recessive_bit;          // One recessive bit sampled.
      logic dominant_bit;           // One dominant bit sampled.
      logic [2:0] tx_done;          // Buffer sent successfully.
      logic [2:0] tx_abortable;     // Not started, or lost / errored.
   } engine_ev_t;

   typedef enum logic [1:0] {
      BO_IDLE,
      BO_ACTIVE,
      BO_RECOVERED
   } busoff_state_t;
endpackage
